/* File: pmesp_pkg.sv */
package pmesp_pkg;
  // Number of event sources feeding the status alert
  localparam int unsigned EVENT_COUNT = 8;
  // Number of buck rails and LDO rails watched by the rails-ok logic
  localparam int unsigned BUCK_COUNT = 3;
  localparam int unsigned LDO_COUNT = 2;
  // Depth of the input synchroniser
  localparam int unsigned SYNC_STAGES = 2;
  // Values after reset
  localparam logic RST_EVENT_BIT = 1'b0;
  localparam logic RST_SYNC_BIT = 1'b0;
  localparam logic RST_PIN_BIT = 1'b1;

  // Power state of the output regulators
  typedef enum logic [1:0] {
    PMESP_OFF,
    PMESP_ON,
    PMESP_FORCED_OFF
  } pmesp_pwr_t;
endpackage : pmesp_pkg

/* File: pmesp_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module pmesp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // Both stages; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pmesp_sync_state_t;

  pmesp_sync_state_t st_r; // Registered state
  pmesp_sync_state_t st_nxt; // Next state

  // Shift the pin level through two stages
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.meta = d;
      st_nxt.stable = st_r.meta;
    end
  end

  // Register the state; both stages clear to the reset level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.meta <= {WIDTH{pmesp_pkg::RST_SYNC_BIT}};
      st_r.stable <= {WIDTH{pmesp_pkg::RST_SYNC_BIT}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;
endmodule // pmesp_sync

/* File: pmesp_enable_status.sv */
`timescale 1ns/1ps
module pmesp_enable_status #(
  parameter int unsigned EVENTS = pmesp_pkg::EVENT_COUNT,
  parameter int unsigned BUCKS = pmesp_pkg::BUCK_COUNT,
  parameter int unsigned LDOS = pmesp_pkg::LDO_COUNT
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Regulator-enable pin from the host
  input wire logic REGULATOR_ENABLE_PIN,
  // Rails-ok pin: input level, output, output enable
  input wire logic RAILS_OK_PIN_I,
  output logic RAILS_OK_PIN_O,
  output logic RAILS_OK_PIN_OE,
  // Rails-ok direction: 1 selects input mode
  input wire logic RAILS_OK_INPUT_MODE,
  // Status alert pin, open drain: output and output enable
  output logic STATUS_ALERT_N_O,
  output logic STATUS_ALERT_N_OE,
  // Event causes, same-clock levels from monitors
  input wire logic [EVENTS-1:0] EVENT_CAUSE,
  // Software clear, one-cycle pulse per event
  input wire logic [EVENTS-1:0] EVENT_CLEAR,
  // Tolerance monitors, same-clock levels
  input wire logic BULK_OK,
  input wire logic [BUCKS-1:0] BUCK_ENABLED,
  input wire logic [BUCKS-1:0] BUCK_OK,
  input wire logic [LDOS-1:0] LDO_OK,
  // Regulator enables toward the analog side
  output logic BUCK_RUN,
  output logic LDO_RUN,
  // Pending event flags for readback
  output logic [EVENTS-1:0] EVENT_PENDING
);

  // All module state except the synchroniser stages
  typedef struct packed {
    logic [EVENTS-1:0] pending;
    pmesp_pkg::pmesp_pwr_t pwr;
    logic rails_low;
  } pmesp_state_t;

  pmesp_state_t st_r; // Registered state
  pmesp_state_t st_nxt; // Next state
  logic en_s; // Synchronised regulator-enable
  logic rok_s; // Synchronised rails-ok input
  logic rails_good; // All watched rails in tolerance

  // Synchronise both pin inputs
  pmesp_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .d({REGULATOR_ENABLE_PIN, RAILS_OK_PIN_I}),
    .q({en_s, rok_s})
  );

  logic forced_req; // Input mode with the pin seen low
  logic alert_any; // At least one flag pending

  // Next value of the event flags
  // A flag is set by its cause and cleared only by a clear
  // that arrives while the cause is gone
  function automatic logic [EVENTS-1:0] pending_next(
    input logic [EVENTS-1:0] cur,
    input logic [EVENTS-1:0] cause,
    input logic [EVENTS-1:0] clear
  );
    logic [EVENTS-1:0] kept;
    // Drop only the flags that software clears
    kept = cur & ~clear;
    // Set wins, so a live cause keeps or re-arms its flag
    return kept | cause;
  endfunction

  // True when any enabled buck is out of tolerance
  // Disabled bucks never count as a fault
  function automatic logic buck_fault_any(
    input logic [BUCKS-1:0] enabled,
    input logic [BUCKS-1:0] ok
  );
    logic [BUCKS-1:0] bad;
    // One bit per enabled and failing buck
    bad = enabled & ~ok;
    return |bad;
  endfunction

  // True when bulk, enabled bucks and every LDO are in tolerance
  function automatic logic rails_in_tol(
    input logic bulk,
    input logic [BUCKS-1:0] enabled,
    input logic [BUCKS-1:0] ok,
    input logic [LDOS-1:0] ldo
  );
    logic good;
    // Bulk below its threshold is a fault on its own
    good = bulk;
    // Any enabled buck out of band is a fault
    if (buck_fault_any(enabled, ok)) begin
      good = 1'b0;
    end
    // Every LDO is watched, whether loaded or not
    if (!(&ldo)) begin
      good = 1'b0;
    end
    return good;
  endfunction

  // Next power state from the synchronised pins
  // A low rails-ok input in input mode keeps or sends the bucks off;
  // the LDOs stay up in that state
  function automatic pmesp_pkg::pmesp_pwr_t pwr_next(
    input pmesp_pkg::pmesp_pwr_t cur,
    input logic en,
    input logic forced
  );
    pmesp_pkg::pmesp_pwr_t nxt;
    // Hold the state unless a pin asks for a change
    nxt = cur;
    case (cur)
      // Off: enable lands in on, or straight in forced off
      pmesp_pkg::PMESP_OFF: begin
        if (en && forced) begin
          // Never pulse the bucks while the pin is held low
          nxt = pmesp_pkg::PMESP_FORCED_OFF;
        end else if (en) begin
          // Normal power-up
          nxt = pmesp_pkg::PMESP_ON;
        end
      end
      // On: enable low turns all off, pin low turns bucks off
      pmesp_pkg::PMESP_ON: begin
        if (!en) begin
          // Enable has priority over the rails-ok input
          nxt = pmesp_pkg::PMESP_OFF;
        end else if (forced) begin
          // Outside party pulls rails-ok low
          nxt = pmesp_pkg::PMESP_FORCED_OFF;
        end
      end
      // Forced off: enable low turns all off; else wait for the pin or the mode to let go
      pmesp_pkg::PMESP_FORCED_OFF: begin
        if (!en) begin
          // Enable low shuts the LDOs as well
          nxt = pmesp_pkg::PMESP_OFF;
        end else if (!forced) begin
          // Pin back high or mode back to output
          nxt = pmesp_pkg::PMESP_ON;
        end
      end
      default: begin
        // Unused code falls back to all off
        nxt = pmesp_pkg::PMESP_OFF;
      end
    endcase
    return nxt;
  endfunction

  // Disabled bucks are ignored, every LDO counts
  assign rails_good = rails_in_tol(BULK_OK, BUCK_ENABLED, BUCK_OK, LDO_OK);
  // Only the synchronised copy of the pin is read here
  assign forced_req = RAILS_OK_INPUT_MODE && !rok_s;
  // Any flag keeps the alert pulled
  assign alert_any = |st_r.pending;

  // Next-state logic; everything holds while the clock enable is low
  always_comb begin
    st_nxt = st_r;
    if (CE) begin
      // Flag stays while cause present; set wins over clear
      st_nxt.pending = pending_next(st_r.pending, EVENT_CAUSE, EVENT_CLEAR);
      // Output mode pulls low on fault, releases when good
      st_nxt.rails_low = !RAILS_OK_INPUT_MODE && !rails_good;
      // Power state from enable pin and rails-ok input
      st_nxt.pwr = pwr_next(st_r.pwr, en_s, forced_req);
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r.pending <= {EVENTS{pmesp_pkg::RST_EVENT_BIT}};
      st_r.pwr <= pmesp_pkg::PMESP_OFF;
      st_r.rails_low <= pmesp_pkg::RST_PIN_BIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Alert is the OR of pending flags, driven low while any set
  assign STATUS_ALERT_N_O = 1'b0;
  assign STATUS_ALERT_N_OE = alert_any;
  // Pull-down only in output mode; released in input mode
  assign RAILS_OK_PIN_O = 1'b0;
  assign RAILS_OK_PIN_OE = st_r.rails_low && !RAILS_OK_INPUT_MODE;
  // Bucks run only when on; LDOs stay on during forced off
  assign BUCK_RUN = (st_r.pwr == pmesp_pkg::PMESP_ON);
  assign LDO_RUN = (st_r.pwr != pmesp_pkg::PMESP_OFF);
  assign EVENT_PENDING = st_r.pending;
endmodule // pmesp_enable_status

/* File: pmesp_enable_status_chk.sv */
`timescale 1ns/1ps
// Watches the enable, rails-ok and alert pins of the block
module pmesp_enable_status_chk #(
  parameter int unsigned EVENTS = 8, BUCKS = 3, LDOS = 2
) (
  input wire logic CLK, RST_N, CE, REGULATOR_ENABLE_PIN, RAILS_OK_PIN_I, RAILS_OK_PIN_OE,
  input wire logic RAILS_OK_INPUT_MODE, STATUS_ALERT_N_OE, BULK_OK, BUCK_RUN, LDO_RUN,
  input wire logic [EVENTS-1:0] EVENT_CAUSE, EVENT_CLEAR, EVENT_PENDING,
  input wire logic [BUCKS-1:0] BUCK_ENABLED, BUCK_OK,
  input wire logic [LDOS-1:0] LDO_OK
);
  // Flags that must survive the next edge
  wire [EVENTS-1:0] keep = EVENT_PENDING & (EVENT_CAUSE | ~EVENT_CLEAR);
  // Any watched rail out of tolerance
  wire bad = !BULK_OK || |(BUCK_ENABLED & ~BUCK_OK) || !(&LDO_OK);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_alert_is_or: assert property (STATUS_ALERT_N_OE == |EVENT_PENDING)
    else $error("alert differs from pending flags");
  a_alert_on_cause: assert property (CE && |EVENT_CAUSE |=> STATUS_ALERT_N_OE)
    else $error("alert missing after cause");
  a_flag_held: assert property (|keep |=> (EVENT_PENDING & $past(keep)) == $past(keep))
    else $error("flag lost without clear and idle cause");
  a_rails_fault: assert property (CE && bad && !RAILS_OK_INPUT_MODE ##1 !RAILS_OK_INPUT_MODE
    |-> RAILS_OK_PIN_OE)
    else $error("rails-ok not pulled on fault");
  a_rails_good: assert property (CE && !bad |=> !RAILS_OK_PIN_OE)
    else $error("rails-ok pulled with rails good");
  a_input_mode: assert property (RAILS_OK_INPUT_MODE |-> !RAILS_OK_PIN_OE)
    else $error("pull-down on in input mode");
  a_forced_off: assert property ((RAILS_OK_INPUT_MODE && !RAILS_OK_PIN_I) [*4] |-> !BUCK_RUN)
    else $error("bucks on with rails-ok held low");
  a_ldo_kept: assert property (REGULATOR_ENABLE_PIN [*4] |-> LDO_RUN)
    else $error("ldo off while enabled");
  a_all_off: assert property (!REGULATOR_ENABLE_PIN [*4] |-> !BUCK_RUN && !LDO_RUN)
    else $error("regulators on while disabled");
endmodule // pmesp_enable_status_chk
bind pmesp_enable_status pmesp_enable_status_chk #(.EVENTS(EVENTS), .BUCKS(BUCKS), .LDOS(LDOS))
  chk_i (.*);

/* File: pmesp_host_model.sv */
`timescale 1ns/1ps
// Host and board side of the enable and rails-ok pins
module pmesp_host_model (
  input wire logic want_en, hold_low, dev_pull,
  output logic en_pin, ok_pin
);
  // Enable always at a defined level, low when unused
  assign en_pin = (want_en === 1'b1);
  // Board pull-up wins unless a party pulls low
  assign ok_pin = !(dev_pull || hold_low);
endmodule // pmesp_host_model

/* File: test_pmesp_enable_status.sv */
`timescale 1ns/1ps
module test_pmesp_enable_status;
  logic clk = 0, rst_n = 0, want = 0, hold = 0, mode = 0, bulk = 1, ce = 1;
  logic [7:0] cause = 8'h00, clr = 8'h00;
  logic [2:0] ben = 3'h7, bok = 3'h7;
  logic [1:0] lok = 2'h3;
  wire en_pin, ok_pin, ok_oe, al_oe, brun, lrun, ok_o, al_o;
  wire [7:0] pend;
  int mismatches = 0, total_checks = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  pmesp_host_model host (.want_en(want), .hold_low(hold), .dev_pull(ok_oe), .en_pin(en_pin),
    .ok_pin(ok_pin));
  pmesp_enable_status uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .REGULATOR_ENABLE_PIN(en_pin),
    .RAILS_OK_PIN_I(ok_pin), .RAILS_OK_PIN_O(ok_o), .RAILS_OK_PIN_OE(ok_oe),
    .RAILS_OK_INPUT_MODE(mode), .STATUS_ALERT_N_O(al_o), .STATUS_ALERT_N_OE(al_oe),
    .EVENT_CAUSE(cause), .EVENT_CLEAR(clr), .BULK_OK(bulk), .BUCK_ENABLED(ben), .BUCK_OK(bok),
    .LDO_OK(lok), .BUCK_RUN(brun), .LDO_RUN(lrun), .EVENT_PENDING(pend));
  task summarize();
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task step(int n);
    repeat (n) @(negedge clk);
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      mismatches++;
      summarize();
    end
  end
  // Set, set-wins clear, cause gone, then clear
  task t_events();
    cause = 8'h08; step(1); cause = 8'h00;
    chk("pending", 8'h08, pend); chk("alert", 8'h01, {7'h00, al_oe});
    chk("alert_o", 8'h00, {7'h00, al_o}); chk("ok_o", 8'h00, {7'h00, ok_o});
    clr = 8'h08; cause = 8'h08; step(1); chk("pending", 8'h08, pend);
    clr = 8'h00; cause = 8'h00; step(1); chk("pending", 8'h08, pend);
    clr = 8'h08; step(1); clr = 8'h00;
    chk("pending", 8'h00, pend); chk("alert", 8'h00, {7'h00, al_oe});
  endtask
  // Clock enable low freezes the flags
  task t_freeze();
    ce = 0; cause = 8'h10; step(2); chk("frozen", 8'h00, pend);
    cause = 8'h00; ce = 1; step(1); chk("frozen", 8'h00, pend);
  endtask
  // Good rails, disabled buck fault, ldo fault, input mode
  task t_rails();
    step(2); chk("pull", 8'h00, {7'h00, ok_oe});
    ben = 3'h5; bok = 3'h5; step(2); chk("pull", 8'h00, {7'h00, ok_oe});
    bulk = 0; step(2); chk("pull", 8'h01, {7'h00, ok_oe});
    bulk = 1; step(2); chk("pull", 8'h00, {7'h00, ok_oe});
    lok = 2'h1; step(2); chk("pull", 8'h01, {7'h00, ok_oe});
    mode = 1; #1 chk("pull", 8'h00, {7'h00, ok_oe});
    mode = 0; lok = 2'h3; ben = 3'h7; bok = 3'h7; step(2);
  endtask
  // Enable, forced off with ldo kept, recover, disable
  task t_power();
    want = 1; step(4); chk("run", 8'h03, {6'h00, brun, lrun});
    mode = 1; hold = 1; step(4); chk("run", 8'h01, {6'h00, brun, lrun});
    hold = 0; step(4); chk("run", 8'h03, {6'h00, brun, lrun});
    mode = 0; want = 0; step(4); chk("run", 8'h00, {6'h00, brun, lrun});
    mode = 1; hold = 1; want = 1; step(4); chk("run", 8'h01, {6'h00, brun, lrun});
    mode = 0; hold = 0; want = 0; step(4); chk("run", 8'h00, {6'h00, brun, lrun});
  endtask
  initial begin
    step(3); rst_n = 1;
    t_events();
    t_freeze();
    t_rails();
    t_power();
    summarize();
  end
endmodule // test_pmesp_enable_status
